// [intc_pkg.sv]
package intc_pkg;
  localparam int ADDR_W = 18;
  localparam int NUM_PINS = 4;
  localparam int NUM_INTERNAL = 9;
  localparam int NUM_SOURCES = 13;
  localparam int VEC_W = 6;
  localparam int SRC_W = 4;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SYSTEM_CONTROL = 16'hfff2;
  localparam logic [15:0] IDX_PIN_SENSE_SELECT = 16'hfff4;
  localparam logic [15:0] IDX_PIN_REQUEST_ENABLE = 16'hfff5;
  localparam logic [15:0] IDX_PIN_REQUEST_FLAGS = 16'hfff6;
  localparam logic [15:0] IDX_PRIORITY_SELECT_A = 16'hfff8;
  localparam logic [15:0] IDX_PRIORITY_SELECT_B = 16'hfff9;
  localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h0b;
  localparam logic [7:0] RST_OTHER = 8'h00;
  localparam int SYSC_USER_ROLE_BIT = 3;
  localparam int SYSC_NMI_EDGE_BIT = 2;
  // register bit of each pin, in pin order ext 0, 1, 4, 5
  localparam int PIN_POS_0 = 0;
  localparam int PIN_POS_1 = 1;
  localparam int PIN_POS_4 = 4;
  localparam int PIN_POS_5 = 5;
  localparam int PRA_EXT0 = 7;
  localparam int PRA_EXT1 = 6;
  localparam int PRA_EXT45 = 4;
  localparam int PRA_WATCHDOG = 3;
  localparam int PRA_TMR0 = 2;
  localparam int PRA_TMR1 = 1;
  localparam int PRA_TMR2 = 0;
  localparam int PRB_TMR3 = 7;
  localparam int PRB_TMR4 = 6;
  localparam int PRB_SER0 = 3;
  localparam int PRB_SER1 = 2;
  localparam int PRB_ADC = 1;
  localparam logic [VEC_W-1:0] VEC_NMI = 6'h07;
  // source order: ext0, ext1, ext4, ext5, watchdog, timer 0..4, serial 0..1, a/d
  localparam logic [VEC_W-1:0] SOURCE_VECTOR [NUM_SOURCES] = '{
    6'h0c, 6'h0d, 6'h10, 6'h11, 6'h14, 6'h18, 6'h1c,
    6'h20, 6'h24, 6'h28, 6'h34, 6'h38, 6'h3c};
endpackage : intc_pkg

// [intc_links.sv]
`timescale 1ns/1ps
interface pin_flags_if #(parameter int N = 4);
  logic [N-1:0] sense;
  logic [N-1:0] clear_sw;
  logic [N-1:0] clear_ack;
  logic [N-1:0] flags;
  modport ctrl (output sense, output clear_sw, output clear_ack, input flags);
  modport det (input sense, input clear_sw, input clear_ack, output flags);
endinterface : pin_flags_if

interface arb_if #(parameter int N = 13, parameter int W = 4);
  logic [N-1:0] eligible;
  logic [N-1:0] level;
  logic grant_valid;
  logic [W-1:0] grant_index;
  logic grant_level;
  modport ctrl (output eligible, output level, input grant_valid, input grant_index,
    input grant_level);
  modport arb (input eligible, input level, output grant_valid, output grant_index,
    output grant_level);
endinterface : arb_if

// [pin_request_detect.sv]
`timescale 1ns/1ps
module pin_request_detect #(
  parameter int N = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // async reset, active high
  input wire logic hw_standby, // synchronous reinit
  input wire logic [N-1:0] pin_n, // request pins, active low
  pin_flags_if.det fl // flags and clears
);
  logic [N-1:0] pin_prev;
  logic [N-1:0] next_pin_prev;
  logic [N-1:0] flags;
  logic [N-1:0] next_flags;
  logic [N-1:0] set;

  always_comb
  begin
    next_pin_prev = pin_n;
    // low level or falling edge sets
    set = (~fl.sense & ~pin_n) | (fl.sense & pin_prev & ~pin_n);
    // set wins over a clear in the same cycle, so a level request stays pending
    if (hw_standby)
    begin
      next_flags = '0;
    end
    else
    begin
      next_flags = (flags & ~(fl.clear_sw | fl.clear_ack)) | set;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      pin_prev <= '1;
      flags <= '0;
    end
    else
    begin
      pin_prev <= next_pin_prev;
      flags <= next_flags;
    end
  end

  assign fl.flags = flags;
endmodule : pin_request_detect

// [priority_arbiter.sv]
`timescale 1ns/1ps
module priority_arbiter #(
  parameter int N = 13,
  parameter int W = 4
) (
  arb_if.arb a // eligible requests in, winner out
);
  always_comb
  begin
    a.grant_valid = 1'b0;
    a.grant_index = '0;
    a.grant_level = 1'b0;
    // high level first, then lowest vector
    for (int i = N - 1; i >= 0; i--)
    begin
      if (a.eligible[i] && !a.level[i])
      begin
        a.grant_valid = 1'b1;
        a.grant_index = W'(i);
      end
    end
    for (int i = N - 1; i >= 0; i--)
    begin
      if (a.eligible[i] && a.level[i])
      begin
        a.grant_valid = 1'b1;
        a.grant_index = W'(i);
        a.grant_level = 1'b1;
      end
    end
  end
endmodule : priority_arbiter

// [two_level_interrupt_controller.sv]
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module two_level_interrupt_controller (
  input wire logic clk_sys, // 200 MHz system clock
  input wire logic reset, // async reset, active high
  input wire logic hw_standby, // hardware standby, reinitialises registers
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [intc_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic nmi_pin, // nonmaskable request pin
  input wire logic [intc_pkg::NUM_PINS-1:0] ext_request_n, // pins 0, 1, 4, 5, low active
  input wire logic [intc_pkg::NUM_INTERNAL-1:0] internal_req, // on-chip module requests
  input wire logic cpu_global_mask, // cpu global mask bit
  input wire logic user_flag_bit, // cpu user flag bit
  input wire logic irq_accept, // cpu takes presented request
  output logic irq_request, // request to cpu
  output logic [intc_pkg::VEC_W-1:0] irq_vector, // vector of presented request
  output logic irq_level, // level of presented request
  output logic irq_nmi, // presented request is nonmaskable
  output logic [7:0] system_control, // system control register
  output logic user_flag_role_select // 0 user flag masks, 1 plain bit
);
  import intc_pkg::*;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
    addr_hit = (addr == {idx, 2'b00});
  endfunction : addr_hit

  function automatic logic [7:0] pack_pins(input logic [NUM_PINS-1:0] v);
    pack_pins = 8'h00;
    pack_pins[PIN_POS_0] = v[0];
    pack_pins[PIN_POS_1] = v[1];
    pack_pins[PIN_POS_4] = v[2];
    pack_pins[PIN_POS_5] = v[3];
  endfunction : pack_pins

  function automatic logic [NUM_PINS-1:0] unpack_pins(input logic [7:0] r);
    unpack_pins = {r[PIN_POS_5], r[PIN_POS_4], r[PIN_POS_1], r[PIN_POS_0]};
  endfunction : unpack_pins

  pin_flags_if #(.N(NUM_PINS)) fl ();
  arb_if #(.N(NUM_SOURCES), .W(SRC_W)) arb ();

  logic [7:0] pin_sense_select;
  logic [7:0] pin_request_enable;
  logic [7:0] priority_select_a;
  logic [7:0] priority_select_b;
  logic [NUM_PINS-1:0] read_armed;
  logic [7:0] next_system_control;
  logic [7:0] next_pin_sense_select;
  logic [7:0] next_pin_request_enable;
  logic [7:0] next_priority_select_a;
  logic [7:0] next_priority_select_b;
  logic [NUM_PINS-1:0] next_read_armed;
  logic [31:0] next_prdata;

  logic nmi_prev;
  logic nmi_primed;
  logic nmi_pending;
  logic next_nmi_prev;
  logic next_nmi_primed;
  logic next_nmi_pending;
  logic nmi_edge;

  logic [SRC_W-1:0] served_index;
  logic [SRC_W-1:0] next_served_index;
  logic next_irq_request;
  logic [VEC_W-1:0] next_irq_vector;
  logic next_irq_level;
  logic next_irq_nmi;

  logic setup_phase;
  logic access_phase;
  logic reg_hit;
  logic wr_low;
  logic take_served;
  logic pass_level0;
  logic pass_level1;
  logic [NUM_SOURCES-1:0] requests;
  logic [NUM_PINS-1:0] ack_pins;

  pin_request_detect #(.N(NUM_PINS)) u_detect (
    .clk_sys(clk_sys),
    .reset(reset),
    .hw_standby(hw_standby),
    .pin_n(ext_request_n),
    .fl(fl)
  );

  priority_arbiter #(.N(NUM_SOURCES), .W(SRC_W)) u_arbiter (
    .a(arb)
  );

  // register bus decode
  always_comb
  begin
    setup_phase = psel && !penable;
    access_phase = psel && penable;
    reg_hit = addr_hit(paddr, IDX_SYSTEM_CONTROL) || addr_hit(paddr, IDX_PIN_SENSE_SELECT)
      || addr_hit(paddr, IDX_PIN_REQUEST_ENABLE) || addr_hit(paddr, IDX_PIN_REQUEST_FLAGS)
      || addr_hit(paddr, IDX_PRIORITY_SELECT_A) || addr_hit(paddr, IDX_PRIORITY_SELECT_B);
    // only the low byte holds register bits; other lanes are ignored
    wr_low = access_phase && pwrite && pstrb[0];
  end

  // zero wait states: read data is captured in setup, so every access ends at once
  assign pready = 1'b1;
  assign pslverr = access_phase && !reg_hit;

  // register writes and read data
  always_comb
  begin
    next_system_control = system_control;
    next_pin_sense_select = pin_sense_select;
    next_pin_request_enable = pin_request_enable;
    next_priority_select_a = priority_select_a;
    next_priority_select_b = priority_select_b;
    next_prdata = prdata;
    if (setup_phase && !pwrite)
    begin
      next_prdata = 32'h0000_0000;
      if (addr_hit(paddr, IDX_SYSTEM_CONTROL))
      begin
        next_prdata[7:0] = system_control;
      end
      else if (addr_hit(paddr, IDX_PIN_SENSE_SELECT))
      begin
        next_prdata[7:0] = pin_sense_select;
      end
      else if (addr_hit(paddr, IDX_PIN_REQUEST_ENABLE))
      begin
        next_prdata[7:0] = pin_request_enable;
      end
      else if (addr_hit(paddr, IDX_PIN_REQUEST_FLAGS))
      begin
        // spare flag positions read as zero
        next_prdata[7:0] = pack_pins(fl.flags);
      end
      else if (addr_hit(paddr, IDX_PRIORITY_SELECT_A))
      begin
        next_prdata[7:0] = priority_select_a;
      end
      else if (addr_hit(paddr, IDX_PRIORITY_SELECT_B))
      begin
        next_prdata[7:0] = priority_select_b;
      end
    end
    if (wr_low)
    begin
      if (addr_hit(paddr, IDX_SYSTEM_CONTROL))
      begin
        next_system_control = pwdata[7:0];
      end
      else if (addr_hit(paddr, IDX_PIN_SENSE_SELECT))
      begin
        next_pin_sense_select = pwdata[7:0];
      end
      else if (addr_hit(paddr, IDX_PIN_REQUEST_ENABLE))
      begin
        next_pin_request_enable = pwdata[7:0];
      end
      else if (addr_hit(paddr, IDX_PRIORITY_SELECT_A))
      begin
        next_priority_select_a = pwdata[7:0];
      end
      else if (addr_hit(paddr, IDX_PRIORITY_SELECT_B))
      begin
        next_priority_select_b = pwdata[7:0];
      end
    end
    if (hw_standby)
    begin
      next_system_control = RST_SYSTEM_CONTROL;
      next_pin_sense_select = RST_OTHER;
      next_pin_request_enable = RST_OTHER;
      next_priority_select_a = RST_OTHER;
      next_priority_select_b = RST_OTHER;
    end
  end

  // flag clearing by software
  always_comb
  begin
    fl.clear_sw = '0;
    next_read_armed = read_armed & fl.flags;
    if (wr_low && addr_hit(paddr, IDX_PIN_REQUEST_FLAGS))
    begin
      fl.clear_sw = read_armed & ~unpack_pins(pwdata[7:0]);
      next_read_armed = read_armed & ~fl.clear_sw;
    end
    else if (access_phase && !pwrite && addr_hit(paddr, IDX_PIN_REQUEST_FLAGS))
    begin
      next_read_armed = read_armed | unpack_pins(prdata[7:0]);
    end
    if (hw_standby)
    begin
      next_read_armed = '0;
    end
  end

  assign fl.sense = unpack_pins(pin_sense_select);

  // nonmaskable edge detection
  always_comb
  begin
    next_nmi_prev = nmi_pin;
    next_nmi_primed = 1'b1;
    if (system_control[SYSC_NMI_EDGE_BIT])
    begin
      nmi_edge = nmi_primed && !nmi_prev && nmi_pin;
    end
    else
    begin
      nmi_edge = nmi_primed && nmi_prev && !nmi_pin;
    end
    next_nmi_pending = nmi_pending;
    if (take_served && irq_nmi)
    begin
      next_nmi_pending = 1'b0;
    end
    // an edge in the service cycle is kept
    if (nmi_edge)
    begin
      next_nmi_pending = 1'b1;
    end
    if (hw_standby)
    begin
      next_nmi_pending = 1'b0;
    end
  end

  // masking and priority levels
  always_comb
  begin
    requests = {internal_req, fl.flags & unpack_pins(pin_request_enable)};
    arb.level = {priority_select_b[PRB_ADC], priority_select_b[PRB_SER1],
      priority_select_b[PRB_SER0], priority_select_b[PRB_TMR4],
      priority_select_b[PRB_TMR3], priority_select_a[PRA_TMR2],
      priority_select_a[PRA_TMR1], priority_select_a[PRA_TMR0],
      priority_select_a[PRA_WATCHDOG], priority_select_a[PRA_EXT45],
      priority_select_a[PRA_EXT45], priority_select_a[PRA_EXT1],
      priority_select_a[PRA_EXT0]};
    pass_level0 = !cpu_global_mask;
    if (user_flag_role_select)
    begin
      pass_level1 = !cpu_global_mask;
    end
    else
    begin
      pass_level1 = !user_flag_bit;
    end
    for (int i = 0; i < NUM_SOURCES; i++)
    begin
      arb.eligible[i] = requests[i] && (arb.level[i] ? pass_level1 : pass_level0);
    end
  end

  assign user_flag_role_select = system_control[SYSC_USER_ROLE_BIT];

  // request presented to the cpu
  always_comb
  begin
    take_served = irq_accept && irq_request;
    ack_pins = '0;
    if (take_served && !irq_nmi && served_index < SRC_W'(NUM_PINS))
    begin
      ack_pins[served_index[1:0]] = 1'b1;
    end
    // drop the request for one cycle after service so the stale flag is not shown
    next_irq_request = (nmi_pending || arb.grant_valid) && !take_served;
    next_served_index = arb.grant_index;
    if (nmi_pending)
    begin
      next_irq_vector = VEC_NMI;
      next_irq_level = 1'b1;
      next_irq_nmi = 1'b1;
    end
    else
    begin
      next_irq_vector = SOURCE_VECTOR[arb.grant_index];
      next_irq_level = arb.grant_level;
      next_irq_nmi = 1'b0;
    end
  end

  assign fl.clear_ack = ack_pins;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      system_control <= RST_SYSTEM_CONTROL;
      pin_sense_select <= RST_OTHER;
      pin_request_enable <= RST_OTHER;
      priority_select_a <= RST_OTHER;
      priority_select_b <= RST_OTHER;
      read_armed <= '0;
      prdata <= 32'h0000_0000;
      nmi_prev <= 1'b0;
      nmi_primed <= 1'b0;
      nmi_pending <= 1'b0;
      served_index <= '0;
      irq_request <= 1'b0;
      irq_vector <= '0;
      irq_level <= 1'b0;
      irq_nmi <= 1'b0;
    end
    else
    begin
      system_control <= next_system_control;
      pin_sense_select <= next_pin_sense_select;
      pin_request_enable <= next_pin_request_enable;
      priority_select_a <= next_priority_select_a;
      priority_select_b <= next_priority_select_b;
      read_armed <= next_read_armed;
      prdata <= next_prdata;
      nmi_prev <= next_nmi_prev;
      nmi_primed <= next_nmi_primed;
      nmi_pending <= next_nmi_pending;
      served_index <= next_served_index;
      irq_request <= next_irq_request;
      irq_vector <= next_irq_vector;
      irq_level <= next_irq_level;
      irq_nmi <= next_irq_nmi;
    end
  end
endmodule : two_level_interrupt_controller

// [two_level_interrupt_controller_asserts.sv]
`timescale 1ns/1ps
module intc_checker (
  input wire logic clk_sys, // clock
  input wire logic reset, // async reset
  input wire logic hw_standby, // standby reinit
  input wire logic nmi_pin, // nonmaskable pin
  input wire logic cpu_global_mask, // cpu mask
  input wire logic user_flag_bit, // cpu user flag
  input wire logic irq_accept, // cpu take pulse
  input wire logic irq_request, // request to cpu
  input wire logic [intc_pkg::VEC_W-1:0] irq_vector, // vector
  input wire logic irq_level, // level
  input wire logic irq_nmi, // nonmaskable shown
  input wire logic [7:0] system_control, // system control
  input wire logic user_flag_role_select // user flag role
);
  import intc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // outputs are registered, so masks are judged one cycle back
  // irq_nmi may linger through the dropped cycle after service, so judge it while requested
  property p_nmi_vec;
    irq_nmi && irq_request |-> irq_vector == VEC_NMI && irq_level;
  endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("nonmaskable vector wrong");
  property p_reset_val;
    $fell(reset) |-> system_control == RST_SYSTEM_CONTROL && !irq_request;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("reset value wrong");
  property p_standby;
    hw_standby |=> system_control == RST_SYSTEM_CONTROL;
  endproperty
  a_standby: assert property (p_standby) else $error("standby value wrong");
  property p_role;
    user_flag_role_select == system_control[SYSC_USER_ROLE_BIT];
  endproperty
  a_role: assert property (p_role) else $error("role bit wrong");
  property p_accept;
    irq_accept && irq_request |=> !irq_request;
  endproperty
  a_accept: assert property (p_accept) else $error("request not dropped");
  property p_mask_user;
    irq_request && !irq_nmi && $past(user_flag_role_select) |-> !$past(cpu_global_mask);
  endproperty
  a_mask_user: assert property (p_mask_user) else $error("masked request shown");
  property p_mask_mode;
    irq_request && !irq_nmi && !$past(user_flag_role_select)
      |-> (irq_level ? !$past(user_flag_bit) : !$past(cpu_global_mask));
  endproperty
  a_mask_mode: assert property (p_mask_mode) else $error("level mask wrong");
  property p_vec_legal;
    irq_request && !irq_nmi |-> irq_vector inside {6'h0c, 6'h0d, 6'h10, 6'h11, 6'h14,
      6'h18, 6'h1c, 6'h20, 6'h24, 6'h28, 6'h34, 6'h38, 6'h3c};
  endproperty
  a_vec_legal: assert property (p_vec_legal) else $error("vector not legal");
  property p_nmi_fall;
    $fell(nmi_pin) && !system_control[SYSC_NMI_EDGE_BIT] |-> ##[0:2] irq_nmi;
  endproperty
  a_nmi_fall: assert property (p_nmi_fall) else $error("falling edge missed");
  property p_nmi_rise;
    $rose(nmi_pin) && system_control[SYSC_NMI_EDGE_BIT] |-> ##[0:2] irq_nmi;
  endproperty
  a_nmi_rise: assert property (p_nmi_rise) else $error("rising edge missed");
  c_nmi: cover property (irq_nmi && irq_accept);
  c_high: cover property (irq_request && irq_level && !irq_nmi);
  c_mask: cover property (irq_request && !user_flag_role_select);
endmodule : intc_checker

bind two_level_interrupt_controller intc_checker u_chk (.clk_sys, .reset, .hw_standby,
  .nmi_pin, .cpu_global_mask, .user_flag_bit, .irq_accept, .irq_request, .irq_vector,
  .irq_level, .irq_nmi, .system_control, .user_flag_role_select);

// [cpu_model.sv]
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk_sys, // clock
  input wire logic reset, // async reset
  input wire logic take_en, // allow exception handling
  input wire logic [3:0] lag, // cycles before taking
  input wire logic irq_request, // request shown
  input wire logic [intc_pkg::VEC_W-1:0] irq_vector, // vector shown
  output logic irq_accept, // take pulse
  output logic [intc_pkg::VEC_W-1:0] taken_vec, // last vector taken
  output logic [7:0] taken_cnt // number taken
);
  import intc_pkg::*;
  logic [3:0] wait_cnt;
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      irq_accept <= 1'b0;
      wait_cnt <= 4'h0;
      taken_vec <= '0;
      taken_cnt <= 8'h00;
    end
    else if (irq_accept)
    begin
      // one-cycle pulse; the vector is latched at the taking edge
      irq_accept <= 1'b0;
      wait_cnt <= 4'h0;
      if (irq_request)
      begin
        taken_vec <= irq_vector;
        taken_cnt <= taken_cnt + 8'h01;
      end
    end
    else if (take_en && irq_request)
    begin
      if (wait_cnt >= lag)
        irq_accept <= 1'b1;
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
    else
      wait_cnt <= 4'h0;
  end
endmodule : cpu_model

// [two_level_interrupt_controller_test.sv]
`timescale 1ns/1ps
module two_level_interrupt_controller_test;
  import intc_pkg::*;
  logic clk_sys = 0, reset = 1, hw_standby = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf, lag = 4'h0;
  logic pready, pslverr, err, nmi_pin = 1, cpu_global_mask = 0, user_flag_bit = 0;
  logic [NUM_PINS-1:0] ext_request_n = '1;
  logic [NUM_INTERNAL-1:0] internal_req = '0;
  logic irq_accept, irq_request, irq_level, irq_nmi, user_flag_role_select, take_en = 0;
  logic [VEC_W-1:0] irq_vector, taken_vec;
  logic [7:0] system_control, taken_cnt;
  int num_errors = 0, compares = 0;
  always #2.5 clk_sys = ~clk_sys;
  two_level_interrupt_controller dut (.clk_sys, .reset, .hw_standby, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .nmi_pin, .ext_request_n,
    .internal_req, .cpu_global_mask, .user_flag_bit, .irq_accept, .irq_request,
    .irq_vector, .irq_level, .irq_nmi, .system_control, .user_flag_role_select);
  cpu_model cpu (.clk_sys, .reset, .take_en, .lag, .irq_request, .irq_vector, .irq_accept,
    .taken_vec, .taken_cnt);
  task automatic end_sim;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // the idle cycle at the end keeps psel from being driven twice in one step
  task automatic apb(input logic [15:0] idx, input logic wr, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    chk(rd, {24'h0, exp});
  endtask : rdchk
  task automatic t_regs;
    rdchk(IDX_SYSTEM_CONTROL, 8'h0b);
    rdchk(IDX_PIN_SENSE_SELECT, 8'h00);
    rdchk(IDX_PIN_REQUEST_ENABLE, 8'h00);
    rdchk(IDX_PIN_REQUEST_FLAGS, 8'h00);
    rdchk(IDX_PRIORITY_SELECT_A, 8'h00);
    rdchk(IDX_PRIORITY_SELECT_B, 8'h00);
    apb(IDX_PRIORITY_SELECT_A, 1'b1, 8'ha5);
    rdchk(IDX_PRIORITY_SELECT_A, 8'ha5);
    apb(IDX_PRIORITY_SELECT_B, 1'b1, 8'h31);
    rdchk(IDX_PRIORITY_SELECT_B, 8'h31);
    pstrb <= 4'h0;
    apb(IDX_PRIORITY_SELECT_B, 1'b1, 8'hff);
    pstrb <= 4'hf;
    rdchk(IDX_PRIORITY_SELECT_B, 8'h31);
    apb(16'h0123, 1'b0, 8'h00);
    chk({31'h0, err}, 32'h1);
    apb(IDX_SYSTEM_CONTROL, 1'b1, 8'h07);
    hw_standby <= 1'b1;
    @(posedge clk_sys);
    hw_standby <= 1'b0;
    rdchk(IDX_SYSTEM_CONTROL, 8'h0b);
    rdchk(IDX_PRIORITY_SELECT_B, 8'h00);
  endtask : t_regs
  task automatic t_prio;
    logic [5:0] va [8] = '{6'd32, 6'd28, 6'd24, 6'd20, 6'd16, 6'd12, 6'd13, 6'd12};
    logic [5:0] vb [8] = '{6'd12, 6'd60, 6'd56, 6'd52, 6'd12, 6'd12, 6'd40, 6'd36};
    logic [7:0] sp;
    logic [15:0] idx;
    ext_request_n <= '0;
    internal_req <= '1;
    apb(IDX_PIN_REQUEST_ENABLE, 1'b1, 8'h33);
    for (int r = 0; r < 2; r++)
    begin
      idx = r ? IDX_PRIORITY_SELECT_B : IDX_PRIORITY_SELECT_A;
      sp = r ? 8'h31 : 8'h20;
      for (int b = 0; b < 8; b++)
      begin
        apb(idx, 1'b1, 8'h01 << b);
        @(posedge clk_sys);
        chk(irq_vector, r ? vb[b] : va[b]);
        chk(irq_level, !sp[b]);
      end
      apb(idx, 1'b1, 8'h00);
    end
  endtask : t_prio
  task automatic t_mask;
    logic rl, m, u;
    apb(IDX_PRIORITY_SELECT_A, 1'b1, 8'h80);
    for (int k = 0; k < 8; k++)
    begin
      {rl, m, u} = k[2:0];
      cpu_global_mask <= m;
      user_flag_bit <= u;
      apb(IDX_SYSTEM_CONTROL, 1'b1, rl ? 8'h0b : 8'h03);
      @(posedge clk_sys);
      chk(irq_request, rl ? !m : !(m && u));
      if (rl ? !m : !(m && u))
        chk(irq_vector, (!rl && u && !m) ? 6'd13 : 6'd12);
    end
    lag <= 4'h3;
    nmi_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(irq_nmi, 1'b1);
    chk(irq_vector, 6'd7);
    take_en <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk(taken_vec, 6'd7);
    chk(irq_request, 1'b0);
    take_en <= 1'b0;
    apb(IDX_SYSTEM_CONTROL, 1'b1, 8'h0f);
    nmi_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(irq_nmi, 1'b1);
    take_en <= 1'b1;
    repeat (10) @(posedge clk_sys);
    take_en <= 1'b0;
    nmi_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(irq_nmi, 1'b0);
    lag <= 4'h0;
    cpu_global_mask <= 1'b0;
    user_flag_bit <= 1'b0;
    ext_request_n <= '1;
    internal_req <= '0;
    apb(IDX_SYSTEM_CONTROL, 1'b1, 8'h0b);
    apb(IDX_PRIORITY_SELECT_A, 1'b1, 8'h00);
  endtask : t_mask
  task automatic t_pins;
    // flags latched from the low pins of the priority sweep
    rdchk(IDX_PIN_REQUEST_FLAGS, 8'h33);
    apb(IDX_PIN_REQUEST_FLAGS, 1'b1, 8'hff);
    rdchk(IDX_PIN_REQUEST_FLAGS, 8'h33);
    apb(IDX_PIN_REQUEST_FLAGS, 1'b1, 8'h00);
    rdchk(IDX_PIN_REQUEST_FLAGS, 8'h00);
    apb(IDX_PIN_REQUEST_ENABLE, 1'b1, 8'h00);
    apb(IDX_PIN_SENSE_SELECT, 1'b1, 8'h33);
    ext_request_n <= 4'b1011;
    @(posedge clk_sys);
    ext_request_n <= 4'b1111;
    rdchk(IDX_PIN_REQUEST_FLAGS, 8'h10);
    chk(irq_request, 1'b0);
    apb(IDX_PIN_REQUEST_ENABLE, 1'b1, 8'h33);
    @(posedge clk_sys);
    chk(irq_vector, 6'd16);
    take_en <= 1'b1;
    repeat (6) @(posedge clk_sys);
    take_en <= 1'b0;
    chk(taken_vec, 6'd16);
    rdchk(IDX_PIN_REQUEST_FLAGS, 8'h00);
    ext_request_n <= 4'b0111;
    repeat (3) @(posedge clk_sys);
    chk(irq_vector, 6'd17);
    rdchk(IDX_PIN_REQUEST_FLAGS, 8'h20);
    apb(IDX_PIN_REQUEST_FLAGS, 1'b1, 8'h00);
    // ext0 falls while ext5 rises; the flag lands one edge before the read setup
    ext_request_n <= 4'b1110;
    @(posedge clk_sys);
    rdchk(IDX_PIN_REQUEST_FLAGS, 8'h01);
    apb(IDX_PIN_REQUEST_FLAGS, 1'b1, 8'h00);
    rdchk(IDX_PIN_REQUEST_FLAGS, 8'h00);
    ext_request_n <= 4'b1111;
  endtask : t_pins
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_regs;
    t_prio;
    t_mask;
    t_pins;
    end_sim;
  end
  // the sequence needs well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    end_sim;
  end
endmodule : two_level_interrupt_controller_test
